// >>> rtl/csbra_dev.sv
// Terminal end: decodes the control byte and answers with the status byte.
// Assumes the channel bytes are synchronous to clock and held by the host.
`include "csbra_defines.svh"
module csbra_dev #(
  parameter logic [15:0] TYPE_ID = 16'h0123, // Arbitrary value
  parameter logic [15:0] FW_VER = 16'h3130, // Arbitrary value
  parameter int unsigned SLOW_CYC = `CSBRA_SLOW_CYC,
  parameter int unsigned FAST_CYC = `CSBRA_FAST_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  csbra_if.dev link,
  output logic [15:0] gain_cal,
  output logic [15:0] offset_cal,
  output logic nv_commit,
  output logic [15:0] process_out,
  output logic unlocked
);
  logic [15:0] regs_q [`CSBRA_NREGS];
  logic [15:0] regs_d [`CSBRA_NREGS];
  logic [7:0] stat_q, stat_d;
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] pout_q, pout_d;
  logic unl_q, unl_d;
  logic [15:0] gain_q, gain_d, offs_q, offs_d;
  logic [25:0] tick_q, tick_d;
  logic commit_q, commit_d;
  logic [7:0] ctl;
  logic [5:0] idx;
  logic [15:0] wword;
  logic [25:0] period;
  logic reg_mode;
  logic wr_cmd;
  logic rd_cmd;
  logic code_ok;
  logic cal_req;

  assign ctl = link.out_chan.ctrl;
  assign idx = ctl[5:0];
  assign wword = {link.out_chan.data_hi, link.out_chan.data_lo};
  assign period = ctl[`CSBRA_BIT_FAST] ? 26'(FAST_CYC - 1) : 26'(SLOW_CYC - 1);
  assign reg_mode = ctl[`CSBRA_BIT_REG];
  assign wr_cmd = reg_mode && ctl[`CSBRA_BIT_WR];
  assign rd_cmd = reg_mode && !ctl[`CSBRA_BIT_WR];
  assign code_ok = (wword == `CSBRA_CODE_WORD);
  // Both step bits at once is ambiguous, so it counts as no request
  assign cal_req = !reg_mode && ctl[`CSBRA_BIT_CAL_EN] && unl_q
    && (ctl[`CSBRA_BIT_UP] ^ ctl[`CSBRA_BIT_DOWN]);

  // Register set; a held write simply stores the same word again
  always_comb begin
    regs_d = regs_q;
    if (wr_cmd) begin
      if (idx == `CSBRA_IDX_CODE) begin
        regs_d[idx] = wword;
      end else if (idx != `CSBRA_IDX_TYPE && idx != `CSBRA_IDX_FW && unl_q) begin
        regs_d[idx] = wword;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `CSBRA_NREGS; i++) begin
        regs_q[i] <= 16'h0000;
      end
    end else begin
      regs_q <= regs_d;
    end
  end

  // Status byte and read data word
  always_comb begin
    stat_d = 8'h00;
    rdata_d = rdata_q;
    if (wr_cmd) begin
      stat_d = {1'b1, 1'b0, idx};
    end else if (rd_cmd) begin
      stat_d = ctl;
      unique case (idx)
        `CSBRA_IDX_TYPE: rdata_d = TYPE_ID;
        `CSBRA_IDX_FW: rdata_d = FW_VER;
        `CSBRA_IDX_CODE: rdata_d = unl_q ? regs_q[idx] : 16'h0000;
        default: rdata_d = regs_q[idx];
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stat_q <= 8'h00;
      rdata_q <= 16'h0000;
    end else begin
      stat_q <= stat_d;
      rdata_q <= rdata_d;
    end
  end

  // Write protection and the storage commit pulse
  always_comb begin
    unl_d = unl_q;
    commit_d = 1'b0;
    if (wr_cmd && idx == `CSBRA_IDX_CODE) begin
      // Only the first cycle of a held reset commits, as unl_q drops then
      commit_d = unl_q && !code_ok;
      unl_d = code_ok;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      unl_q <= 1'b0;
      commit_q <= 1'b0;
    end else begin
      unl_q <= unl_d;
      commit_q <= commit_d;
    end
  end

  // Process data word, kept while register mode borrows the channel
  always_comb begin
    pout_d = reg_mode ? pout_q : wword;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pout_q <= 16'h0000;
    end else begin
      pout_q <= pout_d;
    end
  end

  // Calibration stepping; the rate counter restarts whenever stepping stops
  always_comb begin
    gain_d = gain_q;
    offs_d = offs_q;
    tick_d = 26'h0;
    if (cal_req) begin
      if (tick_q >= period) begin
        if (ctl[`CSBRA_BIT_GAIN]) begin
          gain_d = ctl[`CSBRA_BIT_UP] ? gain_q + 16'h0001 : gain_q - 16'h0001;
        end
        if (ctl[`CSBRA_BIT_OFFS]) begin
          offs_d = ctl[`CSBRA_BIT_UP] ? offs_q + 16'h0001 : offs_q - 16'h0001;
        end
      end else begin
        tick_d = tick_q + 26'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gain_q <= 16'h0000;
      offs_q <= 16'h0000;
      tick_q <= 26'h0;
    end else begin
      gain_q <= gain_d;
      offs_q <= offs_d;
      tick_q <= tick_d;
    end
  end

  // Status in byte 0, data word high then low in bytes 1 and 2
  assign link.in_chan = {stat_q, rdata_q[15:8], rdata_q[7:0]};
  assign gain_cal = gain_q;
  assign offset_cal = offs_q;
  assign nv_commit = commit_q;
  assign process_out = pout_q;
  assign unlocked = unl_q;
endmodule

// >>> rtl/csbra_defines.svh
// Constants for the control/status byte register access block.
// Assumes inclusion by both ends; the interface does not include it; definitions only.
`ifndef CSBRA_DEFINES_SVH
`define CSBRA_DEFINES_SVH
`define CSBRA_BIT_REG 7
`define CSBRA_BIT_WR 6
`define CSBRA_BIT_CAL_EN 6
`define CSBRA_BIT_GAIN 4
`define CSBRA_BIT_OFFS 3
`define CSBRA_BIT_FAST 2
`define CSBRA_BIT_UP 1
`define CSBRA_BIT_DOWN 0
`define CSBRA_IDX_TYPE 6'h08
`define CSBRA_IDX_FW 6'h09
`define CSBRA_IDX_CODE 6'h1f
`define CSBRA_CODE_WORD 16'h1235
`define CSBRA_NREGS 64
`define CSBRA_CLK_HZ 40000000
`define CSBRA_SLOW_MS 1000
`define CSBRA_FAST_MS 50
`define CSBRA_SLOW_CYC ((`CSBRA_CLK_HZ / 1000) * `CSBRA_SLOW_MS)
`define CSBRA_FAST_CYC ((`CSBRA_CLK_HZ / 1000) * `CSBRA_FAST_MS)
`endif

// >>> rtl/csbra_pkg.sv
// Types shared by both ends of the control/status byte link.
// Assumes nothing of its surroundings.
package csbra_pkg;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] data_hi;
    logic [7:0] data_lo;
  } csbra_chan_t;
  typedef enum logic [1:0] {
    CSBRA_IDLE = 2'b00,
    CSBRA_WAIT = 2'b01,
    CSBRA_DONE = 2'b11
  } csbra_hstate_t;
endpackage

// >>> rtl/csbra_if.sv
// Logical channel between coupler (host) and terminal (device).
// Byte 0 is control/status, bytes 1 and 2 the data word, high first.
interface csbra_if;
  csbra_pkg::csbra_chan_t out_chan;
  csbra_pkg::csbra_chan_t in_chan;
  modport host (output out_chan, input in_chan);
  modport dev (input out_chan, output in_chan);
endinterface

// >>> rtl/csbra_host.sv
// Coupler end: issues one register command and waits for its acknowledgment.
// Assumes the device answers on the same clock; process data passes when idle.
`include "csbra_defines.svh"
module csbra_host (
  input wire logic clock,
  input wire logic rstn,
  csbra_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [5:0] cmd_index,
  input wire logic [15:0] cmd_wdata,
  input wire logic [7:0] proc_ctrl,
  input wire logic [15:0] proc_data,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata
);
  csbra_pkg::csbra_hstate_t st_q, st_d;
  csbra_pkg::csbra_chan_t out_q, out_d;
  logic [15:0] rd_q, rd_d;
  logic [7:0] expect_ack;

  assign expect_ack = out_q.ctrl[`CSBRA_BIT_WR] ? {2'b10, out_q.ctrl[5:0]} : out_q.ctrl;

  always_comb begin
    st_d = st_q;
    out_d = out_q;
    rd_d = rd_q;
    unique case (st_q)
      csbra_pkg::CSBRA_IDLE: begin
        out_d = '{ctrl: {1'b0, proc_ctrl[6:0]}, data_hi: proc_data[15:8], data_lo: proc_data[7:0]};
        if (cmd_valid) begin
          out_d = '{ctrl: {1'b1, cmd_write, cmd_index}, data_hi: cmd_wdata[15:8], data_lo: cmd_wdata[7:0]};
          st_d = csbra_pkg::CSBRA_WAIT;
        end
      end
      csbra_pkg::CSBRA_WAIT: begin
        // Command stays on the channel until the receipt appears
        if (link.in_chan.ctrl == expect_ack) begin
          rd_d = {link.in_chan.data_hi, link.in_chan.data_lo};
          st_d = csbra_pkg::CSBRA_DONE;
        end
      end
      csbra_pkg::CSBRA_DONE: begin
        out_d = '{ctrl: {1'b0, proc_ctrl[6:0]}, data_hi: proc_data[15:8], data_lo: proc_data[7:0]};
        st_d = csbra_pkg::CSBRA_IDLE;
      end
      default: st_d = csbra_pkg::CSBRA_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= csbra_pkg::CSBRA_IDLE;
      out_q <= '{ctrl: 8'h00, data_hi: 8'h00, data_lo: 8'h00};
      rd_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      out_q <= out_d;
      rd_q <= rd_d;
    end
  end

  assign link.out_chan = out_q;
  assign cmd_ready = (st_q == csbra_pkg::CSBRA_IDLE);
  assign rsp_valid = (st_q == csbra_pkg::CSBRA_DONE);
  assign rsp_rdata = rd_q;
endmodule

// >>> tb/csbra_sva.sv
// Assertions on the channel between the host and device ends.
// Assumes one clock; instantiated in tb beside the interface.
module csbra_sva (
  input wire logic clock,
  input wire logic rstn,
  input wire csbra_pkg::csbra_chan_t out_chan,
  input wire csbra_pkg::csbra_chan_t in_chan
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_read_echo: assert property (out_chan.ctrl[7:6] == 2'b10 |=> in_chan.ctrl == $past(out_chan.ctrl))
    else $error("read status wrong");
  a_write_ack: assert property (out_chan.ctrl[7:6] == 2'b11 |=>
    in_chan.ctrl == {2'b10, $past(out_chan.ctrl[5:0])}) else $error("write ack wrong");
  a_proc_status: assert property (!out_chan.ctrl[7] |=> in_chan.ctrl == 8'h00)
    else $error("process status not zero");
  a_type_read: assert property (out_chan.ctrl == 8'h88 |=> {in_chan.data_hi, in_chan.data_lo} == 16'h0123)
    else $error("type word wrong");
  a_fw_read: assert property (out_chan.ctrl == 8'h89 |=> {in_chan.data_hi, in_chan.data_lo} == 16'h3130)
    else $error("version word wrong");
  a_code_read: assert property (out_chan.ctrl == 8'h9f |=>
    {in_chan.data_hi, in_chan.data_lo} inside {16'h0000, 16'h1235}) else $error("code word read wrong");
  a_read_stable: assert property (out_chan.ctrl[7:6] == 2'b10 ##1 $stable(out_chan.ctrl) |=>
    $stable({in_chan.data_hi, in_chan.data_lo})) else $error("read changed register");
  a_cmd_hold: assert property ($rose(out_chan.ctrl[7]) |=> $stable(out_chan))
    else $error("command not held");
endmodule

// >>> tb/tb.sv
// Bench: both ends joined by the channel, exercised through the host command port.
// Assumes rsp_valid pulses once per acknowledged command.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rstn, cmd_valid, cmd_ready, cmd_write, rsp_valid, nv_commit, unlocked;
  logic [5:0] cmd_index;
  logic [7:0] proc_ctrl;
  logic [15:0] cmd_wdata, proc_data, rsp_rdata, gain_cal, offset_cal, process_out, rd, g;
  int mismatches = 0;
  int samples_checked = 0;
  int commits = 0;
  csbra_if link ();
  csbra_dev #(.SLOW_CYC(8), .FAST_CYC(2)) u_csbra_dev (.clock(clock), .rstn(rstn), .link(link.dev),
    .gain_cal(gain_cal), .offset_cal(offset_cal), .nv_commit(nv_commit), .process_out(process_out), .unlocked(unlocked));
  csbra_host u_csbra_host (.clock(clock), .rstn(rstn), .link(link.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_index(cmd_index), .cmd_wdata(cmd_wdata),
    .proc_ctrl(proc_ctrl), .proc_data(proc_data), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  csbra_sva u_csbra_sva (.clock(clock), .rstn(rstn), .out_chan(link.out_chan), .in_chan(link.in_chan));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (nv_commit === 1'b1) commits <= commits + 1;
  end
  task automatic report_and_stop();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Request held until the edge where cmd_ready is seen high
  task automatic cmd(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
    int n;
    @(posedge clock);
    cmd_write <= wr;
    cmd_index <= idx;
    cmd_wdata <= wd;
    cmd_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    if (cmd_ready !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    @(posedge clock);
    cmd_valid <= 1'b0;
    do begin
      @(negedge clock);
      n++;
    end while (rsp_valid !== 1'b1 && n < 100);
    if (n >= 100) begin
      mismatches++;
      report_and_stop();
    end
    rd = rsp_rdata;
  endtask
  // Write data of all ones also shows that a read never writes
  task automatic rdchk(input logic [5:0] idx, input logic [15:0] exp);
    cmd(1'b0, idx, 16'hffff);
    check(rd, exp);
  endtask
  task automatic hold(input logic [7:0] c, input int n);
    @(posedge clock);
    proc_ctrl <= c;
    repeat (n) @(posedge clock);
    proc_ctrl <= 8'h00;
    repeat (4) @(negedge clock);
  endtask
  initial begin
    rstn = 1'b0;
    {cmd_valid, cmd_write, cmd_index, cmd_wdata, proc_ctrl, proc_data} = '0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    proc_data <= 16'hbeef;
    hold(8'h56, 20);
    check(process_out, 16'hbeef);
    check(gain_cal, 16'h0000);
    rdchk(6'h09, 16'h3130);
    rdchk(6'h08, 16'h0123);
    rdchk(6'h1f, 16'h0000);
    cmd(1'b1, 6'h05, 16'ha55a);
    rdchk(6'h05, 16'h0000);
    cmd(1'b1, 6'h1f, 16'h1235);
    check(16'(unlocked), 16'h0001);
    rdchk(6'h1f, 16'h1235);
    cmd(1'b1, 6'h05, 16'ha55a);
    rdchk(6'h05, 16'ha55a);
    rdchk(6'h05, 16'ha55a);
    cmd(1'b1, 6'h3f, 16'h0f0f);
    rdchk(6'h3f, 16'h0f0f);
    rdchk(6'h25, 16'h0000);
    cmd(1'b1, 6'h08, 16'hffff);
    rdchk(6'h08, 16'h0123);
    hold(8'h56, 40);
    check(16'(gain_cal >= 16'd17 && gain_cal <= 16'd20), 16'h0001);
    check(offset_cal, 16'h0000);
    g = gain_cal;
    hold(8'h4a, 40);
    check(16'(offset_cal >= 16'd3 && offset_cal <= 16'd5), 16'h0001);
    check(gain_cal, g);
    hold(8'h16, 20);
    check(gain_cal, g);
    hold(8'h55, 20);
    check(16'(gain_cal < g), 16'h0001);
    cmd(1'b1, 6'h1f, 16'h0000);
    check(16'(commits), 16'h0001);
    rdchk(6'h1f, 16'h0000);
    report_and_stop();
  end
endmodule
